// >>> ddac_pkg.sv
package ddac_pkg;
   // ************************************************************
   // Register map of the controller
   // ************************************************************
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_CODE_A = 4'h1;
   localparam logic [3:0] ADDR_CODE_B = 4'h2;
   localparam logic [3:0] ADDR_CMD = 4'h3;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   // CTRL fields
   localparam int CTRL_PD_BIT = 0;
   localparam int CTRL_BYTE_BIT = 1;
   localparam int CTRL_GAIN_BIT = 2;
   localparam int CTRL_BUF_BIT = 3;
   localparam int CTRL_DEV_LSB = 4;
   // CMD fields
   localparam int CMD_WR_A_BIT = 0;
   localparam int CMD_WR_B_BIT = 1;
   localparam int CMD_LOAD_BIT = 2;
   localparam int CMD_CLEAR_BIT = 3;
   // STATUS fields
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_PEND_A_BIT = 1;
   localparam int STAT_PEND_B_BIT = 2;
   localparam int STAT_PDWAIT_BIT = 3;
   // Code word layout on the data bus
   localparam int CODE_BITS = 12;
   localparam int LOW_BITS = 8;
   localparam int HIGH_BITS = 4;
   localparam int BYTE_GAIN_POS = 4;
   localparam int BYTE_BUF_POS = 5;
   localparam int WORD_GAIN_POS = 12;
   localparam int WORD_BUF_POS = 13;
   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CLK_MHZ = 40;
   localparam int STROBE_NS = 50;
   localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
   localparam int PD_EXIT_NS = 5000;
   localparam int PD_EXIT_CYC = (PD_EXIT_NS * CLK_MHZ + 999) / 1000;
   localparam logic [7:0] CNT_ZERO = 8'h00;
   typedef enum logic [2:0] {
      DDAC_IDLE, DDAC_SETUP, DDAC_STROBE, DDAC_HOLD, DDAC_LOAD, DDAC_CLEAR
   } ddac_state_t;
endpackage

// >>> ddac_host.sv
`timescale 1ns/10ps
// Function
// - Low byte bits 0-7, high bits 8-11
// - Gain and buffer above code on wide bus
// - Bus at least 14 bits wide
// - Select only one device at a time
// - Hold selects inactive while address changes; byte mode low half: byte_half_select drops at the edge the selects rise
module ddac_host #(
   parameter int NUM_DEV = 4,
   parameter int BUS_W = 16,
   parameter int PD_EXIT_CYCLES = ddac_pkg::PD_EXIT_CYC
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [3:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [31:0] rdata,
   output logic [NUM_DEV-1:0] chip_select_n,
   output logic write_n,
   output logic channel_select,
   output logic byte_half_select,
   output logic [BUS_W-1:0] data_line,
   output logic output_load_n,
   output logic clear_all_n,
   output logic power_down_n
);
   import ddac_pkg::*;

   localparam int DEV_W = (NUM_DEV > 1) ? $clog2(NUM_DEV) : 1;

   // ************************************************************
   // Software state
   // ************************************************************
   logic pd_req, byte_mode, gain, bufr;
   logic [DEV_W-1:0] dev;
   logic [CODE_BITS-1:0] code_a, code_b;
   logic pend_a, pend_b, do_load, do_clear;
   logic next_pd_req, next_byte_mode, next_gain, next_bufr;
   logic [DEV_W-1:0] next_dev;
   logic [CODE_BITS-1:0] next_code_a, next_code_b;
   logic next_pend_a, next_pend_b, next_do_load, next_do_clear;
   logic [31:0] next_rdata;

   // ************************************************************
   // Sequencer state
   // ************************************************************
   ddac_state_t state, next_state;
   logic [7:0] cnt, next_cnt;
   logic [15:0] pd_cnt, next_pd_cnt;
   logic cur_ch, next_cur_ch;
   logic cur_high, next_cur_high;
   logic [NUM_DEV-1:0] next_cs_n;
   logic next_write_n, next_channel_select, next_byte_half_select;
   logic [BUS_W-1:0] next_data_line;
   logic next_output_load_n, next_clear_all_n, next_power_down_n;
   logic busy, take_a, take_b;

   function automatic logic [BUS_W-1:0] bus_word(
      input logic [CODE_BITS-1:0] code, input logic hi,
      input logic bm, input logic g, input logic b);
      logic [BUS_W-1:0] w;
      w = '0;
      if (bm) begin
         if (hi) begin
            w[HIGH_BITS-1:0] = code[CODE_BITS-1:LOW_BITS];
            w[BYTE_GAIN_POS] = g;
            w[BYTE_BUF_POS] = b;
         end else begin
            w[LOW_BITS-1:0] = code[LOW_BITS-1:0];
         end
      end else begin
         w[CODE_BITS-1:0] = code;
         w[WORD_GAIN_POS] = g;
         w[WORD_BUF_POS] = b;
      end
      return w;
   endfunction

   assign busy = (state != DDAC_IDLE) | pend_a | pend_b | do_load
      | do_clear;
   assign take_a = (state == DDAC_IDLE) & pend_a;
   assign take_b = (state == DDAC_IDLE) & ~pend_a & pend_b;

   always_comb begin
      next_pd_req = pd_req;
      next_byte_mode = byte_mode;
      next_gain = gain;
      next_bufr = bufr;
      next_dev = dev;
      next_code_a = code_a;
      next_code_b = code_b;
      next_pend_a = pend_a & ~take_a;
      next_pend_b = pend_b & ~take_b;
      next_do_load = do_load;
      next_do_clear = do_clear;
      next_rdata = '0;
      if (wr_stb) begin
         unique case (addr)
            ADDR_CTRL: begin
               next_pd_req = wdata[CTRL_PD_BIT];
               next_byte_mode = wdata[CTRL_BYTE_BIT];
               next_gain = wdata[CTRL_GAIN_BIT];
               next_bufr = wdata[CTRL_BUF_BIT];
               next_dev = wdata[CTRL_DEV_LSB +: DEV_W];
            end
            ADDR_CODE_A: next_code_a = wdata[CODE_BITS-1:0];
            ADDR_CODE_B: next_code_b = wdata[CODE_BITS-1:0];
            ADDR_CMD: begin
               // Requests are sticky until the sequencer takes them
               if (wdata[CMD_WR_A_BIT]) next_pend_a = 1'b1;
               if (wdata[CMD_WR_B_BIT]) next_pend_b = 1'b1;
               if (wdata[CMD_LOAD_BIT]) next_do_load = 1'b1;
               if (wdata[CMD_CLEAR_BIT]) next_do_clear = 1'b1;
            end
            default: ;
         endcase
      end
      if (state == DDAC_IDLE && !pend_a && !pend_b && do_clear)
         next_do_clear = 1'b0;
      else if (state == DDAC_IDLE && !pend_a && !pend_b && do_load)
         next_do_load = 1'b0;
      if (rd_stb) begin
         unique case (addr)
            ADDR_CTRL: begin
               next_rdata[CTRL_PD_BIT] = pd_req;
               next_rdata[CTRL_BYTE_BIT] = byte_mode;
               next_rdata[CTRL_GAIN_BIT] = gain;
               next_rdata[CTRL_BUF_BIT] = bufr;
               next_rdata[CTRL_DEV_LSB +: DEV_W] = dev;
            end
            ADDR_CODE_A: next_rdata[CODE_BITS-1:0] = code_a;
            ADDR_CODE_B: next_rdata[CODE_BITS-1:0] = code_b;
            ADDR_STATUS: begin
               next_rdata[STAT_BUSY_BIT] = busy;
               next_rdata[STAT_PEND_A_BIT] = pend_a;
               next_rdata[STAT_PEND_B_BIT] = pend_b;
               next_rdata[STAT_PDWAIT_BIT] = (pd_cnt != '0);
            end
            default: ;
         endcase
      end
   end

   // ************************************************************
   // Pin sequencer
   // ************************************************************
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_cur_ch = cur_ch;
      next_cur_high = cur_high;
      next_cs_n = chip_select_n;
      next_write_n = write_n;
      next_channel_select = channel_select;
      next_byte_half_select = byte_half_select;
      next_data_line = data_line;
      next_output_load_n = output_load_n;
      next_clear_all_n = clear_all_n;
      next_power_down_n = ~pd_req;
      next_pd_cnt = pd_cnt;
      if (pd_req)
         next_pd_cnt = PD_EXIT_CYCLES[15:0];
      else if (pd_cnt != '0)
         next_pd_cnt = pd_cnt - 16'h0001;
      if (cnt != CNT_ZERO) next_cnt = cnt - 8'h01;
      unique case (state)
         DDAC_IDLE: begin
            if (pend_a || pend_b) begin
               // Address settles while every select stays high
               next_cur_ch = ~pend_a;
               next_cur_high = byte_mode;
               next_channel_select = ~pend_a;
               next_byte_half_select = byte_mode;
               next_data_line = bus_word(pend_a ? code_a : code_b,
                  byte_mode, byte_mode, gain, bufr);
               next_cnt = STROBE_CYC[7:0];
               next_state = DDAC_SETUP;
            end else if (do_clear) begin
               next_clear_all_n = 1'b0;
               next_cnt = STROBE_CYC[7:0];
               next_state = DDAC_CLEAR;
            end else if (do_load) begin
               next_output_load_n = 1'b0;
               next_cnt = STROBE_CYC[7:0];
               next_state = DDAC_LOAD;
            end
         end
         DDAC_SETUP: if (cnt == CNT_ZERO) begin
            next_cs_n = '1;
            next_cs_n[dev] = 1'b0;
            next_write_n = 1'b0;
            next_cnt = STROBE_CYC[7:0];
            next_state = DDAC_STROBE;
         end
         DDAC_STROBE: if (cnt == CNT_ZERO) begin
            next_write_n = 1'b1;
            next_cnt = STROBE_CYC[7:0];
            next_state = DDAC_HOLD;
         end
         DDAC_HOLD: if (cnt == CNT_ZERO) begin
            next_cs_n = '1;
            if (cur_high) begin
               // High half first, then low half of the same code
               next_cur_high = 1'b0;
               next_byte_half_select = 1'b0;
               next_data_line = bus_word(cur_ch ? code_b : code_a,
                  1'b0, 1'b1, gain, bufr);
               next_cnt = STROBE_CYC[7:0];
               next_state = DDAC_SETUP;
            end else begin
               next_state = DDAC_IDLE;
            end
         end
         DDAC_LOAD: if (cnt == CNT_ZERO) begin
            next_output_load_n = 1'b1;
            next_state = DDAC_IDLE;
         end
         DDAC_CLEAR: if (cnt == CNT_ZERO) begin
            next_clear_all_n = 1'b1;
            next_state = DDAC_IDLE;
         end
      endcase
   end

   // Reset values mirror the device's own power-on state
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pd_req <= 1'b0;
         byte_mode <= 1'b0;
         gain <= 1'b0;
         bufr <= 1'b0;
         dev <= '0;
         code_a <= '0;
         code_b <= '0;
         pend_a <= 1'b0;
         pend_b <= 1'b0;
         do_load <= 1'b0;
         do_clear <= 1'b0;
         rdata <= '0;
         state <= DDAC_IDLE;
         cnt <= CNT_ZERO;
         pd_cnt <= '0;
         cur_ch <= 1'b0;
         cur_high <= 1'b0;
         chip_select_n <= '1;
         write_n <= 1'b1;
         channel_select <= 1'b0;
         byte_half_select <= 1'b0;
         data_line <= '0;
         output_load_n <= 1'b1;
         clear_all_n <= 1'b1;
         power_down_n <= 1'b1;
      end else begin
         pd_req <= next_pd_req;
         byte_mode <= next_byte_mode;
         gain <= next_gain;
         bufr <= next_bufr;
         dev <= next_dev;
         code_a <= next_code_a;
         code_b <= next_code_b;
         pend_a <= next_pend_a;
         pend_b <= next_pend_b;
         do_load <= next_do_load;
         do_clear <= next_do_clear;
         rdata <= next_rdata;
         state <= next_state;
         cnt <= next_cnt;
         pd_cnt <= next_pd_cnt;
         cur_ch <= next_cur_ch;
         cur_high <= next_cur_high;
         chip_select_n <= next_cs_n;
         write_n <= next_write_n;
         channel_select <= next_channel_select;
         byte_half_select <= next_byte_half_select;
         data_line <= next_data_line;
         output_load_n <= next_output_load_n;
         clear_all_n <= next_clear_all_n;
         power_down_n <= next_power_down_n;
      end
   end
endmodule

// >>> ddac_host_chk.sv
`timescale 1ns/10ps
module ddac_host_chk
   import ddac_pkg::*;
#(
   parameter int NUM_DEV = 4,
   parameter int BUS_W = 16,
   parameter int PD_EXIT_CYCLES = PD_EXIT_CYC
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [3:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic [31:0] rdata,
   input wire logic [NUM_DEV-1:0] chip_select_n,
   input wire logic write_n,
   input wire logic channel_select,
   input wire logic byte_half_select,
   input wire logic [BUS_W-1:0] data_line,
   input wire logic output_load_n,
   input wire logic clear_all_n,
   input wire logic power_down_n
);
   // *****
   // Pin protocol
   // *****
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   property p_one_sel;
      $onehot0(~chip_select_n);
   endproperty
   a_one_sel: assert property (p_one_sel)
      else $error("more than one device selected");
   property p_sel_wr;
      $fell(write_n) |-> chip_select_n != '1;
   endproperty
   a_sel_wr: assert property (p_sel_wr)
      else $error("write strobe without select");
   property p_wr_w;
      $fell(write_n) |-> !write_n[*3] ##1 write_n;
   endproperty
   a_wr_w: assert property (p_wr_w)
      else $error("write strobe width wrong");
   // Device latches on the rise, so select must outlast it
   property p_sel_rise;
      $rose(write_n) |-> chip_select_n != '1;
   endproperty
   a_sel_rise: assert property (p_sel_rise)
      else $error("select gone at strobe rise");
   property p_data;
      !write_n |-> $stable(data_line) && $stable(channel_select)
         && $stable(byte_half_select);
   endproperty
   a_data: assert property (p_data)
      else $error("bus moved during strobe");
   property p_load;
      $fell(output_load_n) |-> !output_load_n[*3] ##1 output_load_n;
   endproperty
   a_load: assert property (p_load)
      else $error("load pulse width wrong");
   property p_clr;
      $fell(clear_all_n) |-> !clear_all_n[*3] ##1 clear_all_n;
   endproperty
   a_clr: assert property (p_clr)
      else $error("clear pulse width wrong");
   property p_excl;
      (!output_load_n || !clear_all_n) |-> write_n;
   endproperty
   a_excl: assert property (p_excl)
      else $error("strobe during load or clear");
   property p_pd;
      wr_stb && addr == ADDR_CTRL |->
         ##2 power_down_n == !$past(wdata[CTRL_PD_BIT], 2);
   endproperty
   a_pd: assert property (p_pd)
      else $error("power down pin wrong");
endmodule
bind ddac_host ddac_host_chk #(.NUM_DEV(NUM_DEV), .BUS_W(BUS_W),
   .PD_EXIT_CYCLES(PD_EXIT_CYCLES)) u_chk (.clk(clk), .arst_n(arst_n),
   .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
   .rdata(rdata), .chip_select_n(chip_select_n), .write_n(write_n),
   .channel_select(channel_select), .byte_half_select(byte_half_select),
   .data_line(data_line), .output_load_n(output_load_n),
   .clear_all_n(clear_all_n), .power_down_n(power_down_n));

// >>> ddac_dev_model.sv
`timescale 1ns/10ps
module ddac_dev_model (
   input wire logic cs_n,
   input wire logic wr_n,
   input wire logic ch,
   input wire logic hbs,
   input wire logic byte_mode,
   input wire logic load_n,
   input wire logic clr_n,
   input wire logic pd_n,
   input wire logic [15:0] db,
   output logic [13:0] in_a,
   output logic [13:0] in_b,
   output logic [13:0] dac_a,
   output logic [13:0] dac_b,
   output logic out_hiz
);
   // *****
   // Input and DAC registers, bits 13 buf, 12 gain
   // *****
   logic [13:0] w;
   logic [1:0] dirty = 2'h0;
   initial in_a = 14'h0000;
   initial in_b = 14'h0000;
   initial dac_a = 14'h0000;
   initial dac_b = 14'h0000;
   assign out_hiz = !pd_n;
   always @(posedge wr_n, negedge clr_n, negedge load_n) begin
      if (!clr_n) begin
         {in_a, in_b, dac_a, dac_b, dirty} = '0;
      end else if (!load_n) begin
         if (dirty[0]) dac_a = in_a;
         if (dirty[1]) dac_b = in_b;
         dirty = 2'h0;
      end else if (!cs_n) begin
         w = ch ? in_b : in_a;
         if (!byte_mode) w = db[13:0];
         else if (hbs) w[13:8] = db[5:0];
         else w[7:0] = db[7:0];
         if (ch) in_b = w;
         else in_a = w;
         dirty[ch] = 1'b1;
      end
   end
endmodule

// >>> tb_top.sv
`timescale 1ns/10ps
module tb_top;
   import ddac_pkg::*;
   // *****
   // Bench
   // *****
   logic clk, arst_n, wr_stb, rd_stb, write_n, channel_select;
   logic byte_half_select, output_load_n, clear_all_n, power_down_n;
   logic bmode;
   logic [3:0] addr, chip_select_n;
   logic [31:0] wdata, rdata, v;
   logic [15:0] data_line;
   logic [13:0] m_ia [4], m_ib [4], m_da [4], m_db [4];
   logic [3:0] m_hz;
   int e_ia [4], e_ib [4], e_da [4], e_db [4];
   int seed, err_total, n_compared, ca, cb, gb;
   ddac_host #(.NUM_DEV(4), .BUS_W(16), .PD_EXIT_CYCLES(4)) u_dut (
      .clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
      .chip_select_n(chip_select_n), .write_n(write_n),
      .channel_select(channel_select), .byte_half_select(byte_half_select),
      .data_line(data_line), .output_load_n(output_load_n),
      .clear_all_n(clear_all_n), .power_down_n(power_down_n));
   for (genvar i = 0; i < 4; i++) begin : g_dev
      ddac_dev_model u_dev (.cs_n(chip_select_n[i]), .wr_n(write_n),
         .ch(channel_select), .hbs(byte_half_select), .byte_mode(bmode),
         .load_n(output_load_n), .clr_n(clear_all_n), .pd_n(power_down_n),
         .db(data_line), .in_a(m_ia[i]), .in_b(m_ib[i]), .dac_a(m_da[i]),
         .dac_b(m_db[i]), .out_hiz(m_hz[i]));
   end
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [31:0] e, g);
      n_compared++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic stop_test();
      $display("Compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
   endtask
   task automatic rdv(input logic [3:0] a, output logic [31:0] r);
      @(posedge clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      #1 r = rdata;
   endtask
   // Bounded poll so a stuck busy flag cannot hang the run
   task automatic wait_idle();
      logic [31:0] s;
      s = '1;
      for (int n = 0; n < 40 && s[2:0] !== 3'h0; n++) rdv(ADDR_STATUS, s);
      chk("busy", 0, s[2:0]);
   endtask
   task automatic check_all();
      for (int i = 0; i < 4; i++) begin
         chk("in_a", e_ia[i], m_ia[i]);
         chk("in_b", e_ib[i], m_ib[i]);
         chk("dac_a", e_da[i], m_da[i]);
         chk("dac_b", e_db[i], m_db[i]);
      end
   endtask
   task automatic zero_exp();
      e_ia = '{default: 0};
      e_ib = '{default: 0};
      e_da = '{default: 0};
      e_db = '{default: 0};
   endtask
   initial begin
      #500000;
      err_total++;
      stop_test();
   end
   initial begin
      seed = 93;
      {arst_n, addr, wdata, wr_stb, rd_stb, bmode} = '0;
      zero_exp();
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      chk("cs_n", 4'hf, chip_select_n);
      chk("pd_n", 1, power_down_n);
      check_all();
      rdv(4'hf, v);
      chk("unmapped", 0, v);
      for (int m = 0; m < 2; m++) begin
         bmode = m[0];
         for (int d = 0; d < 4; d++) begin
            ca = $random(seed) & 32'h0fff;
            cb = $random(seed) & 32'h0fff;
            gb = $random(seed) & 3;
            wr(ADDR_CODE_A, ca);
            wr(ADDR_CODE_B, cb);
            wr(ADDR_CTRL, (d << CTRL_DEV_LSB) | (gb << CTRL_GAIN_BIT)
               | (m << CTRL_BYTE_BIT));
            wr(ADDR_CMD, 32'h0000_0003);
            wait_idle();
            e_ia[d] = ca | (gb << 12);
            e_ib[d] = cb | (gb << 12);
            check_all();
            wr(ADDR_CMD, 32'h0000_0004);
            wait_idle();
            e_da = e_ia;
            e_db = e_ib;
            check_all();
         end
      end
      wr(ADDR_CTRL, 32'h0000_0001);
      repeat (3) @(posedge clk);
      chk("pd_n", 0, power_down_n);
      chk("hiz", 4'hf, m_hz);
      wr(ADDR_CTRL, 32'h0000_0000);
      rdv(ADDR_STATUS, v);
      chk("pdwait", 1, v[STAT_PDWAIT_BIT]);
      repeat (8) @(posedge clk);
      rdv(ADDR_STATUS, v);
      chk("pdwait", 0, v[STAT_PDWAIT_BIT]);
      chk("hiz", 0, m_hz);
      check_all();
      wr(ADDR_CMD, 32'h0000_0008);
      wait_idle();
      zero_exp();
      check_all();
      stop_test();
   end
endmodule
